// *** design/dcl_pkg.sv ***
package dcl_pkg;

	localparam int DCL_WAYS    = 4;
	localparam int DCL_SETS    = 16;
	localparam int DCL_SET_W   = 4;
	localparam int DCL_TAG_W   = 8;
	localparam int DCL_LW      = 4;
	localparam int DCL_WAY_W   = DCL_TAG_W + DCL_LW + 1;
	localparam int DCL_ENTRY_W = DCL_WAYS * DCL_WAY_W;

	// Avalon byte offsets
	localparam logic [4:0] DCL_OFS_ADDR = 5'h00;
	localparam logic [4:0] DCL_OFS_CTRL = 5'h04;
	localparam logic [4:0] DCL_OFS_CMD  = 5'h08;
	localparam logic [4:0] DCL_OFS_STAT = 5'h0C;

	// Control register fields
	localparam int DCL_CTRL_MASK_LSB = 0;
	localparam int DCL_CTRL_MODE_BIT = 4;
	localparam int DCL_CTRL_SC_LSB   = 5;
	localparam int DCL_CTRL_FULL_BIT = 7;
	localparam logic [7:0]  DCL_CTRL_RST = 8'h10;
	localparam logic [11:0] DCL_ADDR_RST = 12'h000;
	localparam logic [3:0]  DCL_LFSR_RST = 4'h9;

	// Command codes
	localparam logic [2:0] DCL_OP_READ  = 3'h0;
	localparam logic [2:0] DCL_OP_WRITE = 3'h1;
	localparam logic [2:0] DCL_OP_INVAL = 3'h2;
	localparam logic [2:0] DCL_OP_PUSH  = 3'h3;
	localparam logic [2:0] DCL_OP_SNRD  = 3'h4;
	localparam logic [2:0] DCL_OP_SNWR  = 3'h5;

	localparam logic [1:0] DCL_SC_LEAVE = 2'h1;
	localparam logic [1:0] DCL_SC_INVAL = 2'h2;

	localparam logic [1:0] DCL_LS_INV = 2'h0;
	localparam logic [1:0] DCL_LS_VAL = 2'h1;
	localparam logic [1:0] DCL_LS_DRT = 2'h2;

	// Action bit positions
	localparam int DCL_A_FETCH = 0;
	localparam int DCL_A_BUF   = 1;
	localparam int DCL_A_WB    = 2;
	localparam int DCL_A_MEMWR = 3;
	localparam int DCL_A_INH   = 4;
	localparam int DCL_A_SRC   = 5;
	localparam int DCL_A_SINK  = 6;
	localparam int DCL_A_DLV   = 7;

	typedef enum logic [2:0] {
		DCL_S_IDLE,
		DCL_S_READ,
		DCL_S_DECIDE,
		DCL_S_FETCH,
		DCL_S_PUSHWB,
		DCL_S_UPDATE,
		DCL_S_COPYWB
	} dcl_state_t;

endpackage

// *** design/dcl_mem_if.sv ***
interface dcl_mem_if;
	import dcl_pkg::*;
	logic                   rd_en;
	logic                   wr_en;
	logic [DCL_SET_W-1:0]   addr;
	logic [DCL_ENTRY_W-1:0] wr_data;
	logic [DCL_ENTRY_W-1:0] rd_data;

	modport ctl (output rd_en, output wr_en, output addr, output wr_data, input rd_data);
	modport mem (input rd_en, input wr_en, input addr, input wr_data, output rd_data);
endinterface

// *** design/dcl_line_mem.sv ***
module dcl_line_mem
	import dcl_pkg::*;
(
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	dcl_mem_if.mem    m
);

	logic [DCL_ENTRY_W-1:0] mem_q [DCL_SETS];
	logic [DCL_ENTRY_W-1:0] rd_q;

	// Every line starts invalid with clear flags
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			for (int i = 0; i < DCL_SETS; i++) begin
				mem_q[i] <= '0;
			end
		end else if (m.wr_en) begin
			mem_q[m.addr] <= m.wr_data;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			rd_q <= '0;
		end else if (m.rd_en) begin
			rd_q <= mem_q[m.addr];
		end
	end

	assign m.rd_data = rd_q;

endmodule

// *** design/dcl_line_ctrl.sv ***
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
module dcl_line_ctrl
	import dcl_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	output logic             o_busy,
	output logic             o_line_fetch,
	output logic             o_line_writeback,
	output logic             o_mem_write,
	output logic             o_mem_inhibit,
	output logic             o_data_source,
	output logic             o_data_sink,
	output logic             o_data_deliver
);

	dcl_mem_if mif ();

	dcl_line_mem u_mem (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.m         (mif.mem)
	);

	dcl_state_t             state_q;
	logic [11:0]            addr_q;
	logic [7:0]             ctrl_q, plan_q;
	logic [2:0]             op_q;
	logic [3:0]             mask_q, lfsr_q;
	logic [1:0]             sc_q, way_q, pst_q, nst_q;
	logic [DCL_ENTRY_W-1:0] entry_q;
	logic                   mode_q, full_q, hit_q, refused_q;
	logic                   acc_wr, cmd_wr, start;

	// Bus slave: answer one cycle after the request appears
	assign acc_wr  = i_avs_write && !o_avs_waitrequest;
	assign cmd_wr  = acc_wr && (i_avs_address == DCL_OFS_CMD);
	assign start   = cmd_wr && (state_q == DCL_S_IDLE);

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read && o_avs_waitrequest) begin
			case (i_avs_address)
				DCL_OFS_ADDR: o_avs_readdata <= {20'h0_0000, addr_q};
				DCL_OFS_CTRL: o_avs_readdata <= {24'h00_0000, ctrl_q};
				DCL_OFS_STAT: o_avs_readdata <= {15'h0000, refused_q, plan_q,
					nst_q, pst_q, way_q, hit_q, state_q != DCL_S_IDLE};
				default:      o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			addr_q <= DCL_ADDR_RST;
			ctrl_q <= DCL_CTRL_RST;
		end else if (acc_wr && i_avs_address == DCL_OFS_ADDR) begin
			addr_q <= i_avs_writedata[11:0];
		end else if (acc_wr && i_avs_address == DCL_OFS_CTRL) begin
			ctrl_q <= i_avs_writedata[7:0];
		end
	end

	// A command while busy is dropped and flagged; the next accepted one clears it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			refused_q <= 1'b0;
		end else if (cmd_wr && state_q != DCL_S_IDLE) begin
			refused_q <= 1'b1;
		end else if (start) begin
			refused_q <= 1'b0;
		end
	end

	// Access attributes latched with the command, so each access uses its own mode
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			op_q   <= DCL_OP_READ;
			mask_q <= 4'h0;
			mode_q <= 1'b0;
			sc_q   <= 2'h0;
			full_q <= 1'b0;
		end else if (start) begin
			op_q   <= i_avs_writedata[2:0];
			mask_q <= ctrl_q[DCL_CTRL_MASK_LSB +: 4];
			mode_q <= ctrl_q[DCL_CTRL_MODE_BIT];
			sc_q   <= ctrl_q[DCL_CTRL_SC_LSB +: 2];
			full_q <= ctrl_q[DCL_CTRL_FULL_BIT];
		end
	end

	// Free-running LFSR as the replacement source
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			lfsr_q <= DCL_LFSR_RST;
		end else begin
			lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
		end
	end

	// Lookup of the selected set
	logic [DCL_WAYS-1:0]    w_vld, w_hit, w_drt;
	logic [3:0]             w_dfl [DCL_WAYS];
	logic                   hit, has_inv;
	logic [1:0]             hit_way, inv_way, sel_way;
	logic [DCL_ENTRY_W-1:0] rd_ent;
	assign rd_ent = mif.rd_data;

	always_comb begin
		hit     = 1'b0;
		has_inv = 1'b0;
		hit_way = 2'h0;
		inv_way = 2'h0;
		for (int w = 0; w < DCL_WAYS; w++) begin
			w_vld[w] = rd_ent[w*DCL_WAY_W];
			w_dfl[w] = rd_ent[w*DCL_WAY_W+1 +: DCL_LW];
			w_drt[w] = w_vld[w] && (|w_dfl[w]);
			w_hit[w] = w_vld[w] && (rd_ent[w*DCL_WAY_W+5 +: DCL_TAG_W] == addr_q[11:4]);
		end
		for (int w = DCL_WAYS - 1; w >= 0; w--) begin
			if (w_hit[w]) begin
				hit     = 1'b1;
				hit_way = w[1:0];
			end
			if (!w_vld[w]) begin
				has_inv = 1'b1;
				inv_way = w[1:0];
			end
		end
	end

	assign sel_way = hit ? hit_way : (has_inv ? inv_way : lfsr_q[1:0]);
	logic                   s_vld, s_drt;
	logic [3:0]             s_dfl;
	logic [DCL_WAY_W-1:0]   new_way;
	logic [7:0]             plan;
	logic [DCL_ENTRY_W-1:0] nxt_ent;

	assign s_vld = w_vld[sel_way];
	assign s_drt = w_drt[sel_way];
	assign s_dfl = w_dfl[sel_way];

	always_comb begin
		new_way = rd_ent[sel_way*DCL_WAY_W +: DCL_WAY_W];
		plan    = 8'h00;
		case (op_q)
			DCL_OP_READ: begin
				plan[DCL_A_DLV] = 1'b1;
				if (!hit) begin
					plan[DCL_A_FETCH] = 1'b1;
					plan[DCL_A_BUF]   = s_drt;
					plan[DCL_A_WB]    = s_drt;
					new_way = {addr_q[11:4], 4'h0, 1'b1};
				end
			end
			DCL_OP_WRITE: begin
				if (mode_q && hit) begin
					new_way = {addr_q[11:4], s_dfl | mask_q, 1'b1};
				end else if (mode_q) begin
					plan[DCL_A_FETCH] = 1'b1;
					plan[DCL_A_BUF]   = s_drt;
					plan[DCL_A_WB]    = s_drt;
					new_way = {addr_q[11:4], mask_q, 1'b1};
				end else begin
					plan[DCL_A_MEMWR] = 1'b1;
				end
			end
			DCL_OP_INVAL: begin
				if (hit) begin
					new_way = '0;
				end
			end
			DCL_OP_PUSH: begin
				if (hit) begin
					plan[DCL_A_WB] = s_drt;
					new_way = '0;
				end
			end
			DCL_OP_SNRD: begin
				if (hit && (sc_q == DCL_SC_LEAVE || sc_q == DCL_SC_INVAL)) begin
					plan[DCL_A_INH] = s_drt;
					plan[DCL_A_SRC] = s_drt;
					if (sc_q == DCL_SC_INVAL) begin
						new_way = '0;
					end
				end
			end
			DCL_OP_SNWR: begin
				if (hit && sc_q == DCL_SC_INVAL) begin
					new_way = '0;
				end else if (hit && sc_q == DCL_SC_LEAVE) begin
					if (s_drt && !full_q) begin
						plan[DCL_A_INH]  = 1'b1;
						plan[DCL_A_SINK] = 1'b1;
						new_way = {addr_q[11:4], s_dfl | mask_q, 1'b1};
					end else begin
						new_way = '0;
					end
				end
			end
			default: plan = 8'h00;
		endcase
		nxt_ent = rd_ent;
		nxt_ent[sel_way*DCL_WAY_W +: DCL_WAY_W] = new_way;
	end

	// Sequencer: push writes before invalidating, a fill writes the held line last
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			state_q <= DCL_S_IDLE;
		end else begin
			case (state_q)
				DCL_S_IDLE:   state_q <= start ? DCL_S_READ : DCL_S_IDLE;
				DCL_S_READ:   state_q <= DCL_S_DECIDE;
				DCL_S_DECIDE: begin
					if (op_q == DCL_OP_PUSH && plan[DCL_A_WB]) begin
						state_q <= DCL_S_PUSHWB;
					end else if (plan[DCL_A_FETCH]) begin
						state_q <= DCL_S_FETCH;
					end else begin
						state_q <= DCL_S_UPDATE;
					end
				end
				DCL_S_FETCH:  state_q <= DCL_S_UPDATE;
				DCL_S_PUSHWB: state_q <= DCL_S_UPDATE;
				DCL_S_UPDATE: state_q <= plan_q[DCL_A_BUF] ? DCL_S_COPYWB : DCL_S_IDLE;
				DCL_S_COPYWB: state_q <= DCL_S_IDLE;
				default:      state_q <= DCL_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			entry_q <= '0;
			plan_q  <= 8'h00;
			hit_q   <= 1'b0;
			way_q   <= 2'h0;
			pst_q   <= DCL_LS_INV;
			nst_q   <= DCL_LS_INV;
		end else if (state_q == DCL_S_DECIDE) begin
			entry_q <= nxt_ent;
			plan_q  <= plan;
			hit_q   <= hit;
			way_q   <= sel_way;
			pst_q   <= s_drt ? DCL_LS_DRT : (s_vld ? DCL_LS_VAL : DCL_LS_INV);
			nst_q   <= !new_way[0] ? DCL_LS_INV :
				((|new_way[4:1]) ? DCL_LS_DRT : DCL_LS_VAL);
		end
	end

	assign mif.rd_en   = (state_q == DCL_S_READ);
	assign mif.wr_en   = (state_q == DCL_S_UPDATE);
	assign mif.addr    = addr_q[3:0];
	assign mif.wr_data = entry_q;

	// Bus-side outputs straight from flops: strobes one cycle each, busy held through the command
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_busy           <= 1'b0;
			o_line_fetch     <= 1'b0;
			o_line_writeback <= 1'b0;
			o_mem_write      <= 1'b0;
			o_mem_inhibit    <= 1'b0;
			o_data_source    <= 1'b0;
			o_data_sink      <= 1'b0;
			o_data_deliver   <= 1'b0;
		end else begin
			o_busy           <= (state_q != DCL_S_IDLE) || start;
			o_line_fetch     <= (state_q == DCL_S_FETCH);
			o_line_writeback <= (state_q == DCL_S_PUSHWB) || (state_q == DCL_S_COPYWB);
			o_mem_write      <= (state_q == DCL_S_UPDATE) && plan_q[DCL_A_MEMWR];
			o_mem_inhibit    <= (state_q == DCL_S_UPDATE) && plan_q[DCL_A_INH];
			o_data_source    <= (state_q == DCL_S_UPDATE) && plan_q[DCL_A_SRC];
			o_data_sink      <= (state_q == DCL_S_UPDATE) && plan_q[DCL_A_SINK];
			o_data_deliver   <= (state_q == DCL_S_UPDATE) && plan_q[DCL_A_DLV];
		end
	end

	logic dec;
	assign dec = (state_q == DCL_S_DECIDE);

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	a_rdmiss_dirty_order: assert property (
		dec && op_q == DCL_OP_READ && !hit && s_drt |->
			##2 o_line_fetch ##1 o_data_deliver ##1 o_line_writeback)
		else $error("dirty read miss sequence wrong");
	a_rdmiss_clean_fill: assert property (
		dec && op_q == DCL_OP_READ && !hit && !s_drt |->
			##2 o_line_fetch ##1 (o_data_deliver && !o_line_writeback) ##1 !o_line_writeback)
		else $error("clean read miss sequence wrong");
	a_rdhit_no_mem: assert property (
		dec && op_q == DCL_OP_READ && hit |->
			nxt_ent == rd_ent ##2 (o_data_deliver && !o_line_fetch && !o_mem_write))
		else $error("read hit touched memory or state");
	a_cbmiss_alloc: assert property (
		dec && op_q == DCL_OP_WRITE && mode_q && !hit |->
			new_way[4:1] == mask_q && new_way[0] ##2 o_line_fetch)
		else $error("copyback miss did not allocate");
	a_cbmiss_dirty_wb: assert property (
		dec && op_q == DCL_OP_WRITE && mode_q && !hit && s_drt |->
			##2 o_line_fetch ##2 o_line_writeback)
		else $error("dirty victim not written back");
	a_wtmiss_no_alloc: assert property (
		dec && op_q == DCL_OP_WRITE && !mode_q && !hit |->
			nxt_ent == rd_ent ##2 (o_mem_write && !o_line_fetch))
		else $error("write-through miss allocated");
	a_cbhit_flags: assert property (
		dec && op_q == DCL_OP_WRITE && mode_q && hit |->
			new_way[4:1] == (s_dfl | mask_q) ##2 !o_mem_write)
		else $error("copyback hit flags wrong");
	a_wthit_both: assert property (
		dec && op_q == DCL_OP_WRITE && !mode_q && hit |->
			nxt_ent == rd_ent ##2 o_mem_write)
		else $error("write-through hit wrong");
	a_inval_no_wb: assert property (
		dec && op_q == DCL_OP_INVAL && hit |->
			new_way[0] == 1'b0 ##1 !o_line_writeback [*3])
		else $error("invalidate wrote memory");
	a_push_wb_first: assert property (
		dec && op_q == DCL_OP_PUSH && hit && s_drt |->
			##1 (!mif.wr_en && !o_line_writeback) ##1 (o_line_writeback && mif.wr_en))
		else $error("push did not write first");
	a_snrd_source: assert property (
		dec && op_q == DCL_OP_SNRD && hit && s_drt && sc_q[0] != sc_q[1] |->
			##2 (o_mem_inhibit && o_data_source))
		else $error("snoop read did not source");
	a_snwr_inval: assert property (
		dec && op_q == DCL_OP_SNWR && hit && sc_q == DCL_SC_INVAL |->
			!new_way[0] ##2 !o_mem_inhibit)
		else $error("snoop write invalidate wrong");
	a_snwr_sink: assert property (
		dec && op_q == DCL_OP_SNWR && hit && sc_q == DCL_SC_LEAVE && s_drt && !full_q |->
			##2 (o_mem_inhibit && o_data_sink))
		else $error("snoop write did not sink");
	a_fill_invalid: assert property (
		dec && !hit && has_inv |-> !w_vld[sel_way])
		else $error("fill skipped an invalid way");
	a_bus_answer: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus answer late");

	c_dirty_read_miss: cover property (dec && op_q == DCL_OP_READ && !hit && s_drt);
	c_push_dirty:      cover property (dec && op_q == DCL_OP_PUSH && hit && s_drt);
	c_snoop_sink:      cover property (o_data_sink);
	c_refused:         cover property (cmd_wr && state_q != DCL_S_IDLE);

endmodule

// *** verification/dcl_mem_model.sv ***
module dcl_mem_model
	import dcl_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_clr,
	input  wire logic [7:0]  i_pulse,
	output logic      [7:0]  o_seen,
	output logic      [15:0] o_t_fetch,
	output logic      [15:0] o_t_dlv,
	output logic      [15:0] o_t_wb
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] cyc_q = 16'h0000;

	// Passive far side: accepts every fetch, line write and write-through at once.
	// Write-through to dirty lines is accepted too; software should avoid it
	always_ff @(posedge i_clk_sys) begin
		cyc_q <= cyc_q + 16'h0001;
		if (i_clr) begin
			o_seen <= 8'h00;
		end else begin
			o_seen <= o_seen | i_pulse;
		end
	end

	// Stamps kept so the bench can check the order of fetch, delivery and copy-back
	always_ff @(posedge i_clk_sys) begin
		if (i_pulse[DCL_A_FETCH]) begin
			o_t_fetch <= cyc_q;
		end
		if (i_pulse[DCL_A_DLV]) begin
			o_t_dlv <= cyc_q;
		end
		if (i_pulse[DCL_A_WB]) begin
			o_t_wb <= cyc_q;
		end
	end
endmodule

// *** verification/dcl_line_ctrl_tb_top.sv ***
module dcl_line_ctrl_tb_top;
	import dcl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [15:0] M_ALL = 16'hFFF3;
	localparam logic [15:0] M_ACT = 16'hFF01;

	logic        clk           = 1'b0;
	logic        rstn          = 1'b0;
	logic [4:0]  avs_address   = 5'h00;
	logic        avs_read      = 1'b0;
	logic        avs_write     = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        pm_clr        = 1'b0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        busy, fetch, wb, mwr, inh, src, sink, dlv;
	logic [7:0]  pulse, seen;
	logic [15:0] t_f, t_d, t_w;
	logic [31:0] rd;
	int          failures = 0;
	int          checked  = 0;

	always #12.5 clk = ~clk;

	dcl_line_ctrl i_dcl_line_ctrl (
		.i_clk_sys(clk), .i_rstn(rstn), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .o_busy(busy),
		.o_line_fetch(fetch), .o_line_writeback(wb), .o_mem_write(mwr),
		.o_mem_inhibit(inh), .o_data_source(src), .o_data_sink(sink), .o_data_deliver(dlv)
	);

	assign pulse = {dlv, sink, src, inh, mwr, wb, 1'b0, fetch};

	dcl_mem_model i_dcl_mem_model (
		.i_clk_sys(clk), .i_clr(pm_clr), .i_pulse(pulse), .o_seen(seen),
		.o_t_fetch(t_f), .o_t_dlv(t_d), .o_t_wb(t_w)
	);

	task automatic test_done;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Holds the request until waitrequest is sampled low, then frees the bus
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		cmp("bus wait", 32'h2, n);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	function automatic logic [15:0] st(input logic h, input logic [1:0] p, input logic [1:0] n,
			input logic [7:0] a);
		return {a, n, p, 2'b00, h, 1'b0};
	endfunction

	// Runs one command and checks status fields and the pulses seen at the ports
	task automatic op(input logic [11:0] a, input logic [7:0] c, input logic [2:0] k,
			input logic [15:0] e, input logic [15:0] m);
		int n;
		pm_clr <= 1'b1;
		bus(1'b1, DCL_OFS_ADDR, {20'h0, a});
		bus(1'b1, DCL_OFS_CTRL, {24'h0, c});
		pm_clr <= 1'b0;
		bus(1'b1, DCL_OFS_CMD, {29'h0, k});
		cmp("busy", 32'h1, {31'h0, busy});
		n = 0;
		do begin
			bus(1'b0, DCL_OFS_STAT, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
		cmp("status", {16'h0, e & m}, {15'h0, rd[16], rd[15:0] & m});
		cmp("busy idle", 32'h0, {31'h0, busy});
		cmp("pulses", {24'h0, e[15:8] & 8'hFD}, {24'h0, seen});
	endtask

	// Snoop case on a freshly filled line of set 3, made dirty first if asked
	task automatic sn(input logic d, input logic [7:0] c, input logic [2:0] k,
			input logic [15:0] e);
		op(12'h013, 8'h10, DCL_OP_INVAL, 16'h0000, M_ACT);
		op(12'h013, 8'h10, DCL_OP_READ, st(0, 0, 1, 8'h81), M_ALL);
		if (d) begin
			op(12'h013, 8'h11, DCL_OP_WRITE, st(1, 1, 2, 8'h00), M_ALL);
		end
		op(12'h013, c, k, e, M_ALL);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		cmp("watchdog", 32'h0, 32'h1);
		test_done();
	end

	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		bus(1'b0, DCL_OFS_CTRL, 32'h0);
		cmp("ctrl reset", {24'h0, DCL_CTRL_RST}, rd);
		bus(1'b0, DCL_OFS_ADDR, 32'h0);
		cmp("addr reset", {20'h0, DCL_ADDR_RST}, rd);
		bus(1'b0, DCL_OFS_STAT, 32'h0);
		cmp("stat reset", 32'h0, rd);
		bus(1'b1, 5'h14, 32'hFFFF_FFFF);
		bus(1'b0, 5'h10, 32'h0);
		cmp("unmapped read", 32'h0, rd);
		bus(1'b0, DCL_OFS_CTRL, 32'h0);
		cmp("ctrl kept", {24'h0, DCL_CTRL_RST}, rd);
		bus(1'b1, DCL_OFS_ADDR, 32'hFFFF_FFFF);
		bus(1'b0, DCL_OFS_ADDR, 32'h0);
		cmp("addr width", 32'h0000_0FFF, rd);
		bus(1'b0, DCL_OFS_CMD, 32'h0);
		cmp("cmd reads zero", 32'h0, rd);
		op(12'h011, 8'h10, DCL_OP_READ, st(0, 0, 1, 8'h81), M_ALL);
		op(12'h011, 8'h10, DCL_OP_READ, st(1, 1, 1, 8'h80), M_ALL);
		op(12'h011, 8'h13, DCL_OP_WRITE, st(1, 1, 2, 8'h00), M_ALL);
		op(12'h011, 8'h13, DCL_OP_WRITE, st(1, 2, 2, 8'h00), M_ALL);
		op(12'h011, 8'h10, DCL_OP_READ, st(1, 2, 2, 8'h80), M_ALL);
		op(12'h011, 8'h01, DCL_OP_WRITE, st(1, 2, 2, 8'h08), M_ALL);
		op(12'h011, 8'h10, DCL_OP_PUSH, st(1, 2, 0, 8'h04), M_ALL);
		op(12'h011, 8'h10, DCL_OP_READ, st(0, 0, 1, 8'h81), M_ALL);
		op(12'h011, 8'h10, DCL_OP_PUSH, st(1, 1, 0, 8'h00), M_ALL);
		op(12'h011, 8'h10, DCL_OP_PUSH, 16'h0000, M_ACT);
		op(12'h011, 8'h10, DCL_OP_INVAL, 16'h0000, M_ACT);
		op(12'h012, 8'h1F, DCL_OP_WRITE, st(0, 0, 2, 8'h01), M_ALL);
		op(12'h022, 8'h01, DCL_OP_WRITE, st(0, 0, 0, 8'h08), M_ACT);
		op(12'h022, 8'h10, DCL_OP_READ, st(0, 0, 1, 8'h81), M_ALL);
		op(12'h012, 8'h10, DCL_OP_INVAL, st(1, 2, 0, 8'h00), M_ALL);
		op(12'h012, 8'h10, DCL_OP_READ, st(0, 0, 1, 8'h81), M_ALL);
		op(12'h012, 8'h01, DCL_OP_WRITE, st(1, 1, 1, 8'h08), M_ALL);
		op(12'h012, 8'h11, DCL_OP_WRITE, st(1, 1, 2, 8'h00), M_ALL);
		sn(1'b0, 8'h20, DCL_OP_SNRD, st(1, 1, 1, 8'h00));
		sn(1'b1, 8'h20, DCL_OP_SNRD, st(1, 2, 2, 8'h30));
		sn(1'b0, 8'h40, DCL_OP_SNRD, st(1, 1, 0, 8'h00));
		sn(1'b1, 8'h40, DCL_OP_SNRD, st(1, 2, 0, 8'h30));
		sn(1'b0, 8'h40, DCL_OP_SNWR, st(1, 1, 0, 8'h00));
		sn(1'b1, 8'h40, DCL_OP_SNWR, st(1, 2, 0, 8'h00));
		sn(1'b0, 8'h21, DCL_OP_SNWR, st(1, 1, 0, 8'h00));
		sn(1'b1, 8'h21, DCL_OP_SNWR, st(1, 2, 2, 8'h50));
		sn(1'b1, 8'hA1, DCL_OP_SNWR, st(1, 2, 0, 8'h00));
		sn(1'b1, 8'h60, DCL_OP_SNRD, st(1, 2, 2, 8'h00));
		sn(1'b1, 8'h01, DCL_OP_SNWR, st(1, 2, 2, 8'h00));
		for (int s = 4; s < 6; s++) begin
			for (int i = 1; i < 5; i++) begin
				op({8'(i), 4'(s)}, 8'h10, DCL_OP_READ, st(0, 0, 1, 8'h81), M_ALL);
			end
			for (int i = 1; i < 5; i++) begin
				op({8'(i), 4'(s)}, 8'h10, DCL_OP_READ, st(1, 1, 1, 8'h80), M_ALL);
			end
		end
		for (int i = 1; i < 5; i++) begin
			op({8'(i), 4'h4}, 8'h11, DCL_OP_WRITE, st(1, 1, 2, 8'h00), M_ALL);
		end
		op(12'h054, 8'h10, DCL_OP_READ, st(0, 2, 1, 8'h87), M_ALL);
		cmp("fill order", 32'h1, {31'h0, t_f < t_d && t_d < t_w});
		op(12'h054, 8'h11, DCL_OP_WRITE, st(1, 1, 2, 8'h00), M_ALL);
		op(12'h064, 8'h11, DCL_OP_WRITE, st(0, 2, 2, 8'h07), M_ALL);
		cmp("copyback order", 32'h1, {31'h0, t_f < t_w});
		op(12'h055, 8'h10, DCL_OP_READ, st(0, 1, 1, 8'h81), M_ALL);
		bus(1'b1, DCL_OFS_CMD, {29'h0, DCL_OP_READ});
		bus(1'b1, DCL_OFS_CMD, {29'h0, DCL_OP_PUSH});
		repeat (20) @(posedge clk);
		bus(1'b0, DCL_OFS_STAT, 32'h0);
		cmp("refused flag", 32'h1, {31'h0, rd[16]});
		op(12'h055, 8'h10, DCL_OP_READ, st(1, 1, 1, 8'h80), M_ALL);
		test_done();
	end
endmodule
